// ---- design/ctm_regs.svh ----
// constants for the charge-time measurement controller
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH
// ----------------------------------------
// control high field positions
// ----------------------------------------
`define CTM_CONH_UNIT_ENABLE 7
`define CTM_CONH_STOP_IDLE 5
`define CTM_CONH_DELAY_GEN 4
`define CTM_CONH_EDGE_EN 3
`define CTM_CONH_EDGE_SEQ 2
`define CTM_CONH_SRC_GND 1
`define CTM_CONH_TRIG_EN 0
// ----------------------------------------
// control low field positions
// ----------------------------------------
`define CTM_CONL_EDGE2_POL 7
`define CTM_CONL_EDGE2_SEL_HI 6
`define CTM_CONL_EDGE2_SEL_LO 5
`define CTM_CONL_EDGE1_POL 4
`define CTM_CONL_EDGE1_SEL_HI 3
`define CTM_CONL_EDGE1_SEL_LO 2
`define CTM_CONL_EDGE2_FLAG 1
`define CTM_CONL_EDGE1_FLAG 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define CTM_CONH_RESET 8'h00
`define CTM_CONL_RESET 8'h00
`define CTM_ICON_RESET 8'h00
`define CTM_IRNG_OFF 2'h0
`endif

// ---- design/ctm_pkg.sv ----
// types for the charge-time measurement controller
package ctm_pkg;
	typedef enum logic [1:0] {CTM_SRC_EDGE2PIN_B, CTM_SRC_EDGE2PIN_A, CTM_SRC_TRIG1,
		CTM_SRC_TRIG2} ctm_src_raw_t;
	typedef enum {CTM_IDLE, CTM_DRAIN, CTM_CHARGE, CTM_HOLD} ctm_state_t;
endpackage

// ---- design/ctm_edge_sync.sv ----
// synchroniser and edge detector for one edge input pin
`timescale 1ns/1ps
module ctm_edge_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	input wire logic pol_i,
	output logic edge_o
);
	logic s1;
	logic s2;
	logic s3;
	logic next_s1;
	logic next_s2;
	logic next_s3;
	// ----------------------------------------
	// three stages, change counts once s2 and s3 differ
	// ----------------------------------------
	always_comb
	begin
		next_s1 = pin_i;
		next_s2 = s1;
		next_s3 = s2;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
		end
	end
	assign edge_o = pol_i ? (s2 & ~s3) : (~s2 & s3);
endmodule

// ---- design/ctm_ctrl.sv ----
// control sequencing of the charge-time measurement unit
`timescale 1ns/1ps
`include "ctm_regs.svh"
module ctm_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic conh_we_i,
	input wire logic [7:0] conh_wdata_i,
	input wire logic conl_we_i,
	input wire logic [7:0] conl_wdata_i,
	input wire logic icon_we_i,
	input wire logic [7:0] icon_wdata_i,
	input wire logic idle_i,
	input wire logic edge_pin1_i,
	input wire logic edge_pin2_i,
	input wire logic trig1_i,
	input wire logic trig2_i,
	input wire logic comp_trip_i,
	output logic [7:0] conh_o,
	output logic [7:0] conl_o,
	output logic [7:0] icon_o,
	output logic source_on_o,
	output logic source_ground_o,
	output logic [1:0] current_range_o,
	output logic [5:0] current_trim_o,
	output logic adc_trigger_o,
	output logic pulse_out_pin_o
);
	import ctm_pkg::*;
	logic [7:0] conh;
	logic [7:0] conl;
	logic [7:0] icon;
	logic pulse;
	logic next_pulse;
	logic [7:0] next_conh;
	logic [7:0] next_conl;
	logic [7:0] next_icon;
	logic pin1_edge_p;
	logic pin1_edge_n;
	logic pin2_edge_p;
	logic pin2_edge_n;
	logic comp_trip;
	logic trip_d;
	logic next_trip_d;
	logic ev1;
	logic ev2;
	logic unit_enable;
	logic delay_gen_enable;
	logic source_ground_ctl;
	logic first_edge_flag;
	logic second_edge_flag;
	logic active;
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	ctm_edge_sync u_p1p (.clk_i(clk_i), .rst_i(rst_i), .pin_i(edge_pin1_i), .pol_i(1'b1),
		.edge_o(pin1_edge_p));
	ctm_edge_sync u_p1n (.clk_i(clk_i), .rst_i(rst_i), .pin_i(edge_pin1_i), .pol_i(1'b0),
		.edge_o(pin1_edge_n));
	ctm_edge_sync u_p2p (.clk_i(clk_i), .rst_i(rst_i), .pin_i(edge_pin2_i), .pol_i(1'b1),
		.edge_o(pin2_edge_p));
	ctm_edge_sync u_p2n (.clk_i(clk_i), .rst_i(rst_i), .pin_i(edge_pin2_i), .pol_i(1'b0),
		.edge_o(pin2_edge_n));
	ctm_edge_sync u_cmp (.clk_i(clk_i), .rst_i(rst_i), .pin_i(comp_trip_i), .pol_i(1'b1),
		.edge_o(comp_trip));
	assign unit_enable = conh[`CTM_CONH_UNIT_ENABLE];
	assign delay_gen_enable = conh[`CTM_CONH_DELAY_GEN];
	assign source_ground_ctl = conh[`CTM_CONH_SRC_GND];
	assign first_edge_flag = conl[`CTM_CONL_EDGE1_FLAG];
	assign second_edge_flag = conl[`CTM_CONL_EDGE2_FLAG];
	assign active = unit_enable & ~(idle_i & conh[`CTM_CONH_STOP_IDLE]);
	// ----------------------------------------
	// edge source selection
	// ----------------------------------------
	function automatic logic pick(input logic [1:0] sel, input logic pol, input logic a_p,
		input logic a_n, input logic b_p, input logic b_n, input logic t1, input logic t2);
		logic r;
		r = 1'b0;
		case (ctm_src_raw_t'(sel))
			CTM_SRC_EDGE2PIN_A: r = t1;
			CTM_SRC_EDGE2PIN_B: r = t2;
			CTM_SRC_TRIG1: r = pol ? b_p : b_n;
			CTM_SRC_TRIG2: r = pol ? a_p : a_n;
			default: r = 1'b0;
		endcase
		return r;
	endfunction
	always_comb
	begin
		ev1 = conh[`CTM_CONH_EDGE_EN] & pick(conl[`CTM_CONL_EDGE1_SEL_HI:`CTM_CONL_EDGE1_SEL_LO],
			conl[`CTM_CONL_EDGE1_POL], pin1_edge_p, pin1_edge_n, pin2_edge_p, pin2_edge_n,
			trig1_i, trig2_i);
		ev2 = conh[`CTM_CONH_EDGE_EN] & pick(conl[`CTM_CONL_EDGE2_SEL_HI:`CTM_CONL_EDGE2_SEL_LO],
			conl[`CTM_CONL_EDGE2_POL], pin1_edge_p, pin1_edge_n, pin2_edge_p, pin2_edge_n,
			trig1_i, trig2_i);
		if (conh[`CTM_CONH_EDGE_SEQ] & ~first_edge_flag)
			ev2 = 1'b0;
	end
	// ----------------------------------------
	// control bytes; hardware edge set wins over a write
	// ----------------------------------------
	always_comb
	begin
		next_conh = conh_we_i ? (conh_wdata_i & 8'hBF) : conh;
		next_conl = conl_we_i ? conl_wdata_i : conl;
		next_icon = icon_we_i ? icon_wdata_i : icon;
		if (ev1)
			next_conl[`CTM_CONL_EDGE1_FLAG] = 1'b1;
		if (ev2)
			next_conl[`CTM_CONL_EDGE2_FLAG] = 1'b1;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			conh <= `CTM_CONH_RESET;
			conl <= `CTM_CONL_RESET;
			icon <= `CTM_ICON_RESET;
		end
		else
		begin
			conh <= next_conh;
			conl <= next_conl;
			icon <= next_icon;
		end
	end
	// ----------------------------------------
	// delay pulse: starts with first edge, ends at comparator trip
	// ----------------------------------------
	always_comb
	begin
		next_pulse = pulse;
		next_trip_d = trip_d;
		if (!(active && delay_gen_enable) || !first_edge_flag)
		begin
			next_pulse = 1'b0;
			next_trip_d = 1'b0;
		end
		else if (comp_trip || trip_d)
		begin
			next_pulse = 1'b0;
			next_trip_d = 1'b1;
		end
		else
			next_pulse = 1'b1;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pulse <= 1'b0;
			trip_d <= 1'b0;
		end
		else
		begin
			pulse <= next_pulse;
			trip_d <= next_trip_d;
		end
	end
	// ----------------------------------------
	// analog controls
	// ----------------------------------------
	assign source_on_o = active && !source_ground_ctl && first_edge_flag && !second_edge_flag
		&& !(delay_gen_enable && trip_d) && icon[1:0] != `CTM_IRNG_OFF;
	assign source_ground_o = source_ground_ctl;
	assign current_range_o = icon[1:0];
	assign current_trim_o = icon[7:2];
	assign adc_trigger_o = conh[`CTM_CONH_TRIG_EN] & active & second_edge_flag;
	assign pulse_out_pin_o = pulse;
	assign conh_o = conh;
	assign conl_o = conl;
	assign icon_o = icon;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence both_flags_s;
		first_edge_flag && second_edge_flag;
	endsequence
	ground_blocks_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
		source_ground_ctl |-> !source_on_o) else $error("source on while grounded");
	both_flags_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		both_flags_s |-> !source_on_o) else $error("source on with both flags");
	flag_clear_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(first_edge_flag) && !second_edge_flag |-> !source_on_o)
		else $error("charging after flag clear");
	charge_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
		active && first_edge_flag && !second_edge_flag && !source_ground_ctl && !delay_gen_enable
		&& icon[1:0] != 2'h0 |-> source_on_o) else $error("no charge with flag set");
	edge1_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev1 |=> first_edge_flag) else $error("edge one not recorded");
	edge2_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev2 |=> second_edge_flag) else $error("edge two not recorded");
	pulse_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		active && delay_gen_enable && $rose(first_edge_flag) && !comp_trip |=> pulse_out_pin_o)
		else $error("pulse did not start");
	pulse_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pulse_out_pin_o && comp_trip |=> !pulse_out_pin_o [*2])
		else $error("pulse did not end at trip");
	pulse_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!delay_gen_enable |=> !pulse_out_pin_o) else $error("pulse outside delay mode");
endmodule

// ---- testbench/ctm_node_model.sv ----
// behavioural sensing node and comparator on the far side of the unit
`timescale 1ns/1ps
module ctm_node_model #(
	parameter int TRIP_LEVEL = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic source_on_i,
	input wire logic source_ground_i,
	input wire logic [1:0] current_range_i,
	output logic comp_trip_o
);
	int level;
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i || source_ground_i)
			level <= 0;
		else if (source_on_i && current_range_i != 2'h0)
			level <= level + 1;
	end
	// capacitor size sets how long charging takes to trip
	// trip level stands for the channel chosen, bare or with a capacitor
	// bench reads a level only as relative, trip is a plain compare against TRIP_LEVEL
	assign comp_trip_o = (level >= TRIP_LEVEL);
endmodule

// ---- testbench/tb_charge_time_measure_ctrl.sv ----
// self-checking bench for the charge-time measurement controller
`timescale 1ns/1ps
module tb_charge_time_measure_ctrl;
	import ctm_pkg::*;
	localparam int TRIP = 12;
	typedef struct {logic [7:0] h, l, i; logic idle, src, gnd, adc;} ctm_row_t;
	logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, idle = 1'b0, pin1 = 1'b0, pin2 = 1'b0;
	logic trip, src, gnd, adc, pulse;
	logic [7:0] wh = 8'h00, wl = 8'h00, wi = 8'h00, conh, conl, icon;
	logic [1:0] rng;
	logic [5:0] trim;
	int err_count = 0, checks = 0, w;
	ctm_row_t rows [10] = '{'{8'h80, 8'h01, 8'h01, 0, 1, 0, 0}, '{8'h80, 8'h00, 8'h01, 0, 0, 0, 0},
		'{8'hC0, 8'h03, 8'h01, 0, 0, 0, 0}, '{8'h80, 8'h02, 8'h01, 0, 0, 0, 0},
		'{8'h82, 8'h00, 8'h01, 0, 0, 1, 0}, '{8'h80, 8'h01, 8'h00, 0, 0, 0, 0},
		'{8'h00, 8'hFD, 8'hFE, 0, 0, 0, 0}, '{8'hA0, 8'h01, 8'h03, 1, 0, 0, 0},
		'{8'h81, 8'h03, 8'h01, 0, 0, 0, 1}, '{8'h81, 8'h02, 8'h01, 0, 0, 0, 1}};
	ctm_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .conh_we_i(we), .conh_wdata_i(wh),
		.conl_we_i(we), .conl_wdata_i(wl), .icon_we_i(we), .icon_wdata_i(wi), .idle_i(idle),
		.edge_pin1_i(pin1), .edge_pin2_i(pin2), .trig1_i(1'b0), .trig2_i(1'b0),
		.comp_trip_i(trip), .conh_o(conh), .conl_o(conl), .icon_o(icon), .source_on_o(src),
		.source_ground_o(gnd), .current_range_o(rng), .current_trim_o(trim),
		.adc_trigger_o(adc), .pulse_out_pin_o(pulse));
	ctm_node_model #(.TRIP_LEVEL(TRIP)) node_u (.clk_i(clk_i), .rst_i(rst_i),
		.source_on_i(src), .source_ground_i(gnd), .current_range_i(rng), .comp_trip_o(trip));
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end
	task finish_test;
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task tick;
		@(posedge clk_i);
		#2;
	endtask
	task cmp1(input logic g, input logic e);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %0t bit got %b want %b", $time, g, e);
		end
	endtask
	task cmp8(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %0t byte got %h want %h", $time, g, e);
		end
	endtask
	task wr3(input logic [7:0] h, input logic [7:0] l, input logic [7:0] i);
		tick;
		wh = h;
		wl = l;
		wi = i;
		we = 1'b1;
		tick;
		we = 1'b0;
	endtask
	task wait_for(input int k, input logic v);
		for (int n = 0; n < 40 && (k == 0 ? src : pulse) !== v; n++)
			tick;
		if ((k == 0 ? src : pulse) !== v)
		begin
			err_count++;
			$display("[ERR] %0t wait ran out", $time);
			finish_test;
		end
	endtask
	task chk_zero;
		cmp8(conh, 8'h00);
		cmp8(conl, 8'h00);
		cmp8(icon, 8'h00);
		cmp1(src, 1'b0);
		cmp1(pulse, 1'b0);
	endtask
	initial
	begin
		repeat (6) @(posedge clk_i);
		#2;
		rst_i = 1'b0;
		chk_zero;
		foreach (rows[r])
		begin
			wr3(rows[r].h, rows[r].l, rows[r].i);
			idle = rows[r].idle;
			tick;
			tick;
			cmp1(src, rows[r].src);
			cmp1(gnd, rows[r].gnd);
			cmp1(adc, rows[r].adc);
			cmp1(pulse, 1'b0);
			cmp8(conh, rows[r].h & 8'hBF);
			cmp8(conl, rows[r].l);
			cmp8({trim, rng}, rows[r].i);
		end
		idle = 1'b0;
		// edges blocked, then timed charge between two rising edges
		wr3(8'h80, 8'hDC, 8'h01);
		pin1 = 1'b1;
		repeat (6) tick;
		cmp1(conl[0], 1'b0);
		pin1 = 1'b0;
		wr3(8'h89, 8'hDC, 8'h01);
		repeat (4) tick;
		pin1 = 1'b1;
		wait_for(0, 1'b1);
		cmp8(conl, 8'hDD);
		pin2 = 1'b1;
		wait_for(0, 1'b0);
		cmp8(conl, 8'hDF);
		cmp1(adc, 1'b1);
		// drain, then delay generation until the comparator trips
		wr3(8'h92, 8'h00, 8'h01);
		wr3(8'h90, 8'h00, 8'h01);
		wr3(8'h90, 8'h01, 8'h01);
		wait_for(1, 1'b1);
		cmp1(src, 1'b1);
		for (w = 0; w < 200 && pulse === 1'b1; w++)
			tick;
		cmp1(pulse, 1'b0);
		cmp1(w >= TRIP && w < TRIP + 10, 1'b1);
		cmp1(src, 1'b0);
		// reset in mid-run clears everything
		wr3(8'h9F, 8'hFF, 8'hFF);
		rst_i = 1'b1;
		tick;
		chk_zero;
		rst_i = 1'b0;
		tick;
		chk_zero;
		finish_test;
	end
endmodule
